// File: inc/mts_pkg.sv
// Constants shared by the magnetic threshold and status slice
package mts_pkg;

    localparam logic [7:0] MTS_ADDR_SRC    = 8'h64;
    localparam logic [7:0] MTS_ADDR_LIM_LO = 8'h65;
    localparam logic [7:0] MTS_ADDR_LIM_HI = 8'h66;
    localparam logic [7:0] MTS_ADDR_FLAGS  = 8'h67;
    localparam logic [7:0] MTS_ADDR_X_LO   = 8'h68;
    localparam logic [7:0] MTS_ADDR_X_HI   = 8'h69;
    localparam logic [7:0] MTS_ADDR_Y_LO   = 8'h6a;
    localparam logic [7:0] MTS_ADDR_Y_HI   = 8'h6b;
    localparam logic [7:0] MTS_ADDR_Z_LO   = 8'h6c;
    localparam logic [7:0] MTS_ADDR_Z_HI   = 8'h6d;

    localparam logic [7:0]  MTS_LIM_RST    = 8'h00;
    localparam logic [7:0]  MTS_FLAGS_RST  = 8'h00;
    localparam logic [7:0]  MTS_UNMAPPED   = 8'h00;
    localparam logic [15:0] MTS_WORD_RST   = 16'h0000;

    localparam int MTS_AXES      = 3;
    localparam int MTS_WORD_W    = 16;
    localparam int MTS_READ_LAT  = 3;

    // Read pipeline, Gray coded along idle -> fetch -> done
    typedef enum logic [1:0] {
        MTS_RD_IDLE  = 2'b00,
        MTS_RD_FETCH = 2'b01,
        MTS_RD_DONE  = 2'b11
    } mts_rd_state_t;

endpackage

// File: core/mts_word_mem.sv
// Three-word result store with per-word write enables and registered read
`timescale 1ns/1ps
`default_nettype none
module mts_word_mem (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [2:0]       wr_en,
    input  wire logic [2:0][15:0] wr_data,
    input  wire logic [1:0]       rd_idx,
    output logic      [15:0]      rd_data
);
    typedef struct packed {
        logic [2:0][15:0] words;
        logic [15:0]      rd_data;
    } mts_mem_state_t;

    mts_mem_state_t st_reg;
    mts_mem_state_t st_next;

    always_comb begin
        st_next = st_reg;
        // Read sees the word before any write of the same cycle
        st_next.rd_data = (rd_idx < 2'd3) ? st_reg.words[rd_idx] : mts_pkg::MTS_WORD_RST;
        for (int i = 0; i < mts_pkg::MTS_AXES; i++) begin
            if (wr_en[i]) begin
                st_next.words[i] = wr_data[i];
            end
        end
        if (sys_rst) begin
            st_next = '0;
        end
    end

    always_ff @(posedge clk) begin
        st_reg <= st_next;
    end

    assign rd_data = st_reg.rd_data;
endmodule
`default_nettype wire

// File: core/mts_core.sv
// Magnetic limit compare, sample flags and result registers
`timescale 1ns/1ps
`default_nettype none
module mts_core (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [2:0]  sample_valid,
    input  wire logic [15:0] raw_x,
    input  wire logic [15:0] raw_y,
    input  wire logic [15:0] raw_z,
    input  wire logic [15:0] offset_x,
    input  wire logic [15:0] offset_y,
    input  wire logic [15:0] offset_z,
    input  wire logic        x_axis_watch_enable,
    input  wire logic        y_axis_watch_enable,
    input  wire logic        z_axis_watch_enable,
    input  wire logic        event_global_enable,
    input  wire logic        event_polarity,
    input  wire logic        event_latch_select,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_rd,
    input  wire logic        reg_shift,
    output logic      [7:0]  reg_rdata,
    output logic             reg_ack,
    output logic             ser_bit,
    output logic             event_flag
);
    typedef struct packed {
        mts_pkg::mts_rd_state_t rd_state;
        logic [7:0] rd_addr;
        logic [7:0] hold;
        logic [7:0] rdata;
        logic [7:0] shreg;
        logic       ack;
        logic [7:0] lim_lo;
        logic [7:0] lim_hi;
        logic [2:0] da;
        logic [2:0] orr;
        logic       zyxda;
        logic       zyxor;
        logic [2:0] seen;
        logic [2:0] rd_seen;
        logic [2:0] src_p;
        logic [2:0] src_n;
        logic       int_act;
        logic       flag;
    } mts_state_t;

    mts_state_t st_reg;
    mts_state_t st_next;

    logic [2:0][15:0] raw;
    logic [2:0][15:0] off;
    logic [2:0][15:0] corr;
    logic [2:0][15:0] mag;
    logic [2:0]       watch;
    logic [2:0]       en;
    logic [2:0]       pos_hit;
    logic [2:0]       neg_hit;
    logic [2:0]       clr_axis;
    logic [2:0]       read_all;
    logic [15:0]      lim;
    logic [15:0]      mem_rd;
    logic [2:0]       rd_axis;
    logic             rd_take;
    logic             clr_all;
    logic             src_clear;
    logic             act;
    logic [2:0]       req_axis;

    // Axis decode: {hit, index}, index 0 is X
    function automatic logic [2:0] axis_of(input logic [7:0] addr);
        case (addr)
            mts_pkg::MTS_ADDR_X_LO, mts_pkg::MTS_ADDR_X_HI: axis_of = 3'b100;
            mts_pkg::MTS_ADDR_Y_LO, mts_pkg::MTS_ADDR_Y_HI: axis_of = 3'b101;
            mts_pkg::MTS_ADDR_Z_LO, mts_pkg::MTS_ADDR_Z_HI: axis_of = 3'b110;
            default: axis_of = 3'b000;
        endcase
    endfunction

    assign raw   = {raw_z, raw_y, raw_x};
    assign off   = {offset_z, offset_y, offset_x};
    assign watch = {z_axis_watch_enable, y_axis_watch_enable, x_axis_watch_enable};
    assign lim   = {st_reg.lim_hi, st_reg.lim_lo};

    genvar a;
    generate
        for (a = 0; a < mts_pkg::MTS_AXES; a++) begin : g_axis
            // Zero correction leaves the raw word untouched
            assign corr[a]    = raw[a] - off[a];
            assign mag[a]     = 16'(~corr[a] + 16'h0001);
            assign en[a]      = watch[a] & event_global_enable;
            assign pos_hit[a] = ~corr[a][15] & (corr[a] > lim);
            assign neg_hit[a] = corr[a][15] & (mag[a] > lim);
        end
    endgenerate

    mts_word_mem mts_word_mem_inst (
        .clk     (clk),
        .sys_rst (sys_rst),
        .wr_en   (sample_valid),
        .wr_data (corr),
        .rd_idx  (rd_axis[1:0]),
        .rd_data (mem_rd)
    );

    assign rd_axis   = axis_of(st_reg.rd_addr);
    assign req_axis  = axis_of(reg_addr);
    assign rd_take   = reg_rd && (st_reg.rd_state == mts_pkg::MTS_RD_IDLE);
    assign src_clear = rd_take && event_latch_select
                       && (reg_addr == mts_pkg::MTS_ADDR_SRC);
    assign act       = |(en & (pos_hit | neg_hit) & sample_valid);

    always_comb begin
        st_next     = st_reg;
        st_next.ack = 1'b0;
        clr_axis    = 3'b000;
        read_all    = st_reg.rd_seen;
        clr_all     = 1'b0;

        if (reg_wr && reg_addr == mts_pkg::MTS_ADDR_LIM_LO) begin
            st_next.lim_lo = reg_wdata;
        end
        if (reg_wr && reg_addr == mts_pkg::MTS_ADDR_LIM_HI) begin
            st_next.lim_hi = reg_wdata;
        end

        case (st_reg.rd_state)
            mts_pkg::MTS_RD_IDLE: begin
                if (reg_rd) begin
                    st_next.rd_addr  = reg_addr;
                    st_next.rd_state = mts_pkg::MTS_RD_FETCH;
                    case (reg_addr)
                        mts_pkg::MTS_ADDR_SRC:
                            st_next.hold = {st_reg.src_p[0], st_reg.src_p[1], st_reg.src_p[2],
                                            st_reg.src_n[0], st_reg.src_n[1], st_reg.src_n[2],
                                            1'b0, st_reg.flag};
                        mts_pkg::MTS_ADDR_LIM_LO: st_next.hold = st_reg.lim_lo;
                        mts_pkg::MTS_ADDR_LIM_HI: st_next.hold = st_reg.lim_hi;
                        mts_pkg::MTS_ADDR_FLAGS:
                            st_next.hold = {st_reg.zyxor, st_reg.orr,
                                            st_reg.zyxda, st_reg.da};
                        default: st_next.hold = mts_pkg::MTS_UNMAPPED;
                    endcase
                    if (req_axis[2]) begin
                        clr_axis[req_axis[1:0]] = 1'b1;
                    end
                end
            end
            mts_pkg::MTS_RD_FETCH: begin
                st_next.rd_state = mts_pkg::MTS_RD_DONE;
            end
            mts_pkg::MTS_RD_DONE: begin
                // Even address is the low byte of a result word
                if (rd_axis[2]) begin
                    st_next.rdata = st_reg.rd_addr[0] ? mem_rd[15:8] : mem_rd[7:0];
                end else begin
                    st_next.rdata = st_reg.hold;
                end
                st_next.shreg    = st_next.rdata;
                st_next.ack      = 1'b1;
                st_next.rd_state = mts_pkg::MTS_RD_IDLE;
            end
            default: begin
                st_next.rd_state = mts_pkg::MTS_RD_IDLE;
            end
        endcase

        if (reg_shift && !st_reg.ack) begin
            st_next.shreg = {st_reg.shreg[6:0], 1'b0};
        end

        // Reads clear first so a sample in the same cycle still sets
        read_all        = st_reg.rd_seen | clr_axis;
        st_next.da      = st_reg.da & ~clr_axis;
        st_next.orr     = st_reg.orr & ~clr_axis;
        st_next.rd_seen = read_all;
        if (read_all == 3'b111) begin
            clr_all         = 1'b1;
            st_next.zyxda   = 1'b0;
            st_next.zyxor   = 1'b0;
            st_next.rd_seen = 3'b000;
        end

        st_next.orr  = st_next.orr | (sample_valid & st_next.da);
        st_next.da   = st_next.da | sample_valid;
        st_next.seen = st_reg.seen | sample_valid;
        if (st_next.seen == 3'b111) begin
            st_next.zyxor = st_next.zyxor | st_next.zyxda;
            st_next.zyxda = 1'b1;
            st_next.seen  = 3'b000;
        end

        if (src_clear) begin
            st_next.src_p   = 3'b000;
            st_next.src_n   = 3'b000;
            st_next.int_act = 1'b0;
        end
        if (event_latch_select) begin
            st_next.src_p   = st_next.src_p | (en & pos_hit & sample_valid);
            st_next.src_n   = st_next.src_n | (en & neg_hit & sample_valid);
            st_next.int_act = st_next.int_act | act;
        end else begin
            if (|sample_valid) begin
                st_next.src_p = en & pos_hit & sample_valid;
                st_next.src_n = en & neg_hit & sample_valid;
            end
            st_next.int_act = act;
        end
        st_next.flag = event_polarity ? st_next.int_act : ~st_next.int_act;

        if (sys_rst) begin
            st_next        = '0;
            st_next.lim_lo = mts_pkg::MTS_LIM_RST;
            st_next.lim_hi = mts_pkg::MTS_LIM_RST;
            {st_next.zyxor, st_next.orr, st_next.zyxda, st_next.da} = mts_pkg::MTS_FLAGS_RST;
            st_next.flag   = ~event_polarity;
        end
    end

    always_ff @(posedge clk) begin
        st_reg <= st_next;
    end

    assign reg_rdata  = st_reg.rdata;
    assign reg_ack    = st_reg.ack;
    assign ser_bit    = st_reg.shreg[7];
    assign event_flag = st_reg.flag;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence rd_req_s(logic [7:0] addr);
        rd_take && reg_addr == addr;
    endsequence

    sequence ack_s;
        ##3 reg_ack;
    endsequence

    limit_low_write_a: assert property (
        reg_wr && reg_addr == mts_pkg::MTS_ADDR_LIM_LO |=> st_reg.lim_lo == $past(reg_wdata))
        else $error("limit low byte not stored");

    limit_high_write_a: assert property (
        reg_wr && reg_addr == mts_pkg::MTS_ADDR_LIM_HI |=> st_reg.lim_hi == $past(reg_wdata))
        else $error("limit high byte not stored");

    flags_read_ack_a: assert property (
        rd_req_s(mts_pkg::MTS_ADDR_FLAGS) |-> ack_s)
        else $error("flag read not answered in three cycles");

    serial_msb_first_a: assert property (
        reg_ack ##1 (reg_shift && !reg_ack) |=> ser_bit == reg_rdata[6] && !reg_ack)
        else $error("serial order is not msb first");

    all_overrun_set_a: assert property (
        sample_valid == 3'b111 && st_reg.zyxda && !clr_all |=> st_reg.zyxor && st_reg.zyxda)
        else $error("all-axes overrun missed");

    axis_overrun_set_a: assert property (
        sample_valid[0] && st_reg.da[0] && !clr_axis[0] |=> st_reg.orr[0])
        else $error("x overrun missed");

    all_ready_set_a: assert property (
        sample_valid == 3'b111 |=> st_reg.zyxda && st_reg.da == 3'b111)
        else $error("all-axes ready missed");

    pulse_event_a: assert property (
        !event_latch_select && sample_valid[0] && en[0] && (pos_hit[0] || neg_hit[0])
        |=> event_flag == event_polarity)
        else $error("x limit crossing not signalled");

    global_gate_a: assert property (
        !event_global_enable && !event_latch_select |=> event_flag == !$past(event_polarity))
        else $error("event raised while globally disabled");

    latch_hold_a: assert property (
        event_latch_select && st_reg.int_act && !src_clear |=> st_reg.int_act)
        else $error("latched event dropped");

    source_clear_a: assert property (
        rd_req_s(mts_pkg::MTS_ADDR_SRC) && event_latch_select && sample_valid == 3'b000
        |=> st_reg.src_p == 3'b000 && st_reg.src_n == 3'b000 && !st_reg.int_act)
        else $error("source read did not clear");

    axis_read_clear_a: assert property (
        rd_req_s(mts_pkg::MTS_ADDR_X_LO) && !sample_valid[0] |=> !st_reg.da[0] && !st_reg.orr[0])
        else $error("x flags not cleared by read");
endmodule
`default_nettype wire

// File: verif/mts_host_model.sv
// Host-side register master driving the slice's byte access port
`timescale 1ns/1ps
`default_nettype none
module mts_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_ack,
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata,
    output logic            reg_rd,
    output logic            reg_shift
);
    initial begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
        reg_rd    = 1'b0;
        reg_shift = 1'b0;
    end

    // Idle address and data show the inverse of the last value
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clk);
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
        int n;
        ok = 1'b0;
        d  = 8'h00;
        @(negedge clk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge clk);
        reg_rd   = 1'b0;
        reg_addr = ~a;
        for (n = 0; n < 8 && !ok; n++) begin
            @(posedge clk);
            #1;
            if (reg_ack === 1'b1) begin
                ok = 1'b1;
                d  = reg_rdata;
            end
        end
    endtask

    task automatic pulse_shift();
        @(negedge clk);
        reg_shift = 1'b1;
        @(negedge clk);
        reg_shift = 1'b0;
    endtask
endmodule
`default_nettype wire

// File: verif/mag_threshold_status_output_tb_top.sv
// Self-checking bench for the magnetic limit, flag and result slice
`timescale 1ns/1ps
`default_nettype none
module mag_threshold_status_output_tb_top;
    logic        clk;
    logic        sys_rst;
    logic [2:0]  sample_valid;
    logic [15:0] raw_x, raw_y, raw_z, offset_x, offset_y, offset_z;
    logic        x_axis_watch_enable, y_axis_watch_enable, z_axis_watch_enable;
    logic        event_global_enable, event_polarity, event_latch_select;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic        reg_wr, reg_rd, reg_shift, reg_ack, ser_bit, event_flag;
    logic [15:0] words [3];
    int          num_errors;
    int          checks_done;

    mts_core mts_core_inst (.clk(clk), .sys_rst(sys_rst), .sample_valid(sample_valid),
        .raw_x(raw_x), .raw_y(raw_y), .raw_z(raw_z), .offset_x(offset_x),
        .offset_y(offset_y), .offset_z(offset_z), .x_axis_watch_enable(x_axis_watch_enable),
        .y_axis_watch_enable(y_axis_watch_enable), .z_axis_watch_enable(z_axis_watch_enable),
        .event_global_enable(event_global_enable), .event_polarity(event_polarity),
        .event_latch_select(event_latch_select), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_shift(reg_shift),
        .reg_rdata(reg_rdata), .reg_ack(reg_ack), .ser_bit(ser_bit), .event_flag(event_flag));

    mts_host_model mts_host_model_inst (.clk(clk), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_shift(reg_shift));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic tally_and_finish();
        if (num_errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        mts_host_model_inst.rd_reg(a, d, ok);
        if (!ok) begin
            num_errors++;
            tally_and_finish();
        end else begin
            check($sformatf("read %h", a), {8'h00, d}, {8'h00, exp});
        end
    endtask

    // Raw words are inverted once the strobe drops so a late capture shows up
    task automatic sample(input logic [15:0] vx, vy, vz, input logic [2:0] mask);
        @(negedge clk);
        raw_x        = vx;
        raw_y        = vy;
        raw_z        = vz;
        sample_valid = mask;
        @(negedge clk);
        sample_valid = 3'b000;
        raw_x        = ~vx;
        raw_y        = ~vy;
        raw_z        = ~vz;
    endtask

    // Counts active event cycles over a short window after one sample
    task automatic ev(input logic [2:0] mask, input logic [15:0] v, input int exp_hits);
        int hits;
        hits = 0;
        sample(v, v, v, mask);
        repeat (6) begin
            if (event_flag === event_polarity) hits++;
            @(negedge clk);
        end
        check("event cycles", 16'(hits), 16'(exp_hits));
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        tally_and_finish();
    end

    initial begin
        num_errors = 0;
        checks_done = 0;
        sys_rst = 1'b1;
        sample_valid = 3'b000;
        {raw_x, raw_y, raw_z, offset_x, offset_y, offset_z} = '0;
        {x_axis_watch_enable, y_axis_watch_enable, z_axis_watch_enable} = 3'b000;
        {event_global_enable, event_polarity, event_latch_select} = 3'b000;
        repeat (6) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        check("idle event level", {15'h0, event_flag}, 16'h0001);
        rd_chk(8'h67, 8'h00);
        rd_chk(8'h70, 8'h00);
        mts_host_model_inst.wr_reg(8'h65, 8'ha5);
        mts_host_model_inst.wr_reg(8'h66, 8'h3c);
        mts_host_model_inst.wr_reg(8'h67, 8'hff);
        rd_chk(8'h65, 8'ha5);
        rd_chk(8'h66, 8'h3c);
        rd_chk(8'h67, 8'h00);
        words = '{16'h1234, 16'h8001, 16'h00ff};
        sample(words[0], words[1], words[2], 3'b111);
        rd_chk(8'h67, 8'h0f);
        for (int i = 0; i < 6; i++) begin
            rd_chk(8'(8'h68 + i), i[0] ? words[i / 2][15:8] : words[i / 2][7:0]);
        end
        rd_chk(8'h67, 8'h00);
        @(negedge clk);
        offset_x = 16'h0010;
        sample(16'h0005, 16'h0000, 16'h0000, 3'b001);
        rd_chk(8'h67, 8'h01);
        rd_chk(8'h68, 8'hf5);
        rd_chk(8'h69, 8'hff);
        @(negedge clk);
        offset_x = 16'h0000;
        sample(16'h0001, 16'h0002, 16'h0003, 3'b111);
        sample(16'h0004, 16'h0005, 16'h0006, 3'b111);
        rd_chk(8'h67, 8'hff);
        rd_chk(8'h68, 8'h04);
        rd_chk(8'h67, 8'hee);
        @(negedge clk);
        for (int i = 7; i >= 0; i--) begin
            check("serial bit", {15'h0, ser_bit}, {15'h0, 1'(8'hee >> i)});
            mts_host_model_inst.pulse_shift();
            @(negedge clk);
        end
        rd_chk(8'h6a, 8'h05);
        rd_chk(8'h6c, 8'h06);
        rd_chk(8'h67, 8'h00);
        mts_host_model_inst.wr_reg(8'h65, 8'h00);
        mts_host_model_inst.wr_reg(8'h66, 8'h01);
        {x_axis_watch_enable, y_axis_watch_enable, z_axis_watch_enable} = 3'b111;
        event_global_enable = 1'b1;
        for (int p = 0; p < 2; p++) begin
            event_polarity = p[0];
            ev(3'b001, 16'h0101, 1);
            ev(3'b100, 16'hfeff, 1);
            ev(3'b001, 16'h0100, 0);
            ev(3'b010, 16'hff00, 0);
        end
        x_axis_watch_enable = 1'b0;
        ev(3'b001, 16'h0101, 0);
        x_axis_watch_enable = 1'b1;
        event_global_enable = 1'b0;
        ev(3'b001, 16'h0101, 0);
        event_global_enable = 1'b1;
        event_latch_select = 1'b1;
        ev(3'b010, 16'h7fff, 6);
        rd_chk(8'h64, 8'h41);
        check("event after clear", {15'h0, event_flag}, 16'h0000);
        rd_chk(8'h64, 8'h00);
        // Mid-run reset must drop flags and limit and leave the event inactive; no event is latched before it
        sample(16'h0001, 16'h0002, 16'h0003, 3'b111);
        sample(16'h0001, 16'h0002, 16'h0003, 3'b111);
        @(negedge clk);
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        check("event after reset", {15'h0, event_flag}, {15'h0, ~event_polarity});
        rd_chk(8'h67, 8'h00);
        rd_chk(8'h66, 8'h00);
        tally_and_finish();
    end
endmodule
`default_nettype wire
